// ===== aadc_consts.vh
// Constants for the auxiliary converter control block.
`ifndef AADC_CONSTS_VH
`define AADC_CONSTS_VH

// ************************************************************
// Register addresses
// ************************************************************
`define AADC_ADDR_MODE      8'hA7
`define AADC_ADDR_DAC       8'hA8
`define AADC_ADDR_RES1      8'hA9
`define AADC_ADDR_RES2      8'hAA
`define AADC_ADDR_THR       8'hB5

// ************************************************************
// Program block word indices
// ************************************************************
`define AADC_PB_AVG_LOW     4'h0
`define AADC_PB_AVG_HIGH    4'h1
`define AADC_PB_RAMP_STORE  4'hB

// ************************************************************
// Mode register fields
// ************************************************************
`define AADC_MODE_SEL1_LSB  2
`define AADC_MODE_AVG1_LSB  5
`define AADC_MODE_SEL2_LSB  7
`define AADC_MODE_AVG2_LSB  10
`define AADC_SEL_NONE       3'h0

// ************************************************************
// Converter control and data register fields
// ************************************************************
`define AADC_DAC_EN_BIT     15
`define AADC_DAC_CH_LSB     13
`define AADC_DAC_RAMP_BIT   12
`define AADC_THR_CH_BIT     15
`define AADC_THR_HIGH_BIT   14
`define AADC_RES_HIGH_BIT   15
`define AADC_RES_LOW_BIT    14
`define AADC_RESET_VALUE    16'h0000

// ************************************************************
// Widths and timing
// ************************************************************
`define AADC_DW             10
`define AADC_AVG_MAX        4'h8
`define AADC_RAMP_LAST      4'hF
`define AADC_CLK_NS         25
`define AADC_SAMPLE_NS      250000
`define AADC_SAMPLE_CYCLES  (`AADC_SAMPLE_NS / `AADC_CLK_NS)

`endif

// ===== aadc_chan.v
// One auxiliary input channel: rolling average and threshold detection.
`timescale 1ns/10ps
`include "aadc_consts.vh"

module aadc_chan (
	input  wire                      clk_in,
	input  wire                      resetn_in,
	input  wire                      ce_in,
	input  wire                      clear_in,
	input  wire                      sample_in,
	input  wire [`AADC_DW-1:0]       data_in,
	input  wire                      avg_en_in,
	input  wire [3:0]                avg_len_in,
	input  wire [`AADC_DW-1:0]       thr_high_in,
	input  wire [`AADC_DW-1:0]       thr_low_in,
	output wire [`AADC_DW-1:0]       result_out,
	output wire                      above_out,
	output wire                      below_out,
	output wire                      event_out
);
	reg  [`AADC_DW-1:0] result_reg;
	reg  [`AADC_DW-1:0] result_next;
	reg                 above_reg;
	reg                 below_reg;
	reg                 event_reg;
	reg  [3:0]          len;
	reg  signed [`AADC_DW:0] diff;
	reg  signed [`AADC_DW:0] step;
	wire                above_now;
	wire                below_now;
	reg  [`AADC_DW-1:0] sync1_reg;
	reg  [`AADC_DW-1:0] sync2_reg;
	reg  [`AADC_DW-1:0] sync3_reg;
	reg  [`AADC_DW-1:0] word_reg;

	assign above_now  = result_reg > thr_high_in;
	assign below_now  = result_reg < thr_low_in;
	assign result_out = result_reg;
	assign above_out  = above_reg;
	assign below_out  = below_reg;
	assign event_out  = event_reg;

	// ************************************************************
	// Averaging
	// ************************************************************
	// Settings above the top useful value are clamped so the shift stays bounded.
	always @* begin
		len = (avg_len_in > `AADC_AVG_MAX) ? `AADC_AVG_MAX : avg_len_in;
		diff = $signed({1'b0, word_reg}) - $signed({1'b0, result_reg});
		step = diff >>> (len + 4'h1);
		result_next = result_reg;
		if (sample_in) begin
			if (avg_en_in)
				result_next = result_reg + step[`AADC_DW-1:0];
			else
				result_next = word_reg;
		end
	end

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			sync1_reg  <= {`AADC_DW{1'b0}};
			sync2_reg  <= {`AADC_DW{1'b0}};
			sync3_reg  <= {`AADC_DW{1'b0}};
			word_reg   <= {`AADC_DW{1'b0}};
			result_reg <= {`AADC_DW{1'b0}};
			above_reg  <= 1'b0;
			below_reg  <= 1'b0;
			event_reg  <= 1'b0;
		end else if (ce_in) begin
			sync1_reg <= data_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			// A converter word is only taken once two captures agree, so a code caught
			// mid-change never reaches the filter.
			if (sync2_reg == sync3_reg)
				word_reg <= sync3_reg;
			if (clear_in) begin
				result_reg <= {`AADC_DW{1'b0}};
				above_reg  <= 1'b0;
				below_reg  <= 1'b0;
				event_reg  <= 1'b0;
			end else begin
				result_reg <= result_next;
				above_reg  <= above_now;
				below_reg  <= below_now;
				event_reg  <= (above_now & ~above_reg) | (below_now & ~below_reg);
			end
		end
	end
endmodule // aadc_chan

// ===== aadc_top.v
// Auxiliary converter control: two input channels, four outputs and the ramp.
//
// Operation
// - Each input converts from its selected source
// - Average adds fraction of difference each sample
// - Averaging length resets to zero, max eight
// - Averaging starts from current stored value
// - Thresholds compare averaged or raw result
// - Event on rising high or falling low
// - Result read carries threshold status and data
// - One shared register writes one output each
// - Bit twelve makes output one a ramp
// - Raised cosine profile unless host overwrites it
// - Ramp runs only in transmit mode
// - Powersave: enabled outputs follow their levels, others zero, output one in ramp mode excepted
// - General reset clears all control registers
`timescale 1ns/10ps
`include "aadc_consts.vh"

module aadc_top #(
	parameter SAMPLE_CYCLES = `AADC_SAMPLE_CYCLES
) (
	input  wire                clk_in,
	input  wire                resetn_in,
	input  wire                ce_in,
	input  wire                greset_in,
	input  wire                wr_in,
	input  wire                rd_in,
	input  wire [7:0]          addr_in,
	input  wire [15:0]         wdata_in,
	output wire [15:0]         rdata_out,
	input  wire                prog_wr_in,
	input  wire [3:0]          prog_addr_in,
	input  wire [15:0]         prog_data_in,
	input  wire                tx_mode_in,
	input  wire                powersave_in,
	input  wire [`AADC_DW-1:0] adc1_data_in,
	input  wire [`AADC_DW-1:0] adc2_data_in,
	output wire [2:0]          adc1_select_out,
	output wire [2:0]          adc2_select_out,
	output wire [1:0]          adc_event_out,
	output wire [`AADC_DW-1:0] dac1_out,
	output wire [`AADC_DW-1:0] dac2_out,
	output wire [`AADC_DW-1:0] dac3_out,
	output wire [`AADC_DW-1:0] dac4_out,
	output wire [3:0]          dac_enable_out,
	output wire                ramp_busy_out
);
	// ************************************************************
	// Declarations
	// ************************************************************
	reg  [15:0]         mode_reg;
	reg  [`AADC_DW-1:0] thr_high_reg [0:1];
	reg  [`AADC_DW-1:0] thr_low_reg  [0:1];
	reg  [3:0]          avg_len_reg  [0:1];
	reg  [`AADC_DW-1:0] dac_lvl_reg  [0:3];
	reg  [`AADC_DW-1:0] dac_out_reg  [0:3];
	reg  [3:0]          dac_en_reg;
	reg  [`AADC_DW-1:0] profile_mem  [0:15];
	reg                 user_profile_reg;
	reg  [3:0]          prof_ptr_reg;
	reg                 ramp_mode_reg;
	reg                 ramp_active_reg;
	reg                 ramp_up_reg;
	reg  [3:0]          ramp_idx_reg;
	reg  [3:0]          ramp_rate_reg;
	reg  [3:0]          ramp_div_reg;
	reg  [13:0]         tick_cnt_reg;
	reg                 tick_reg;
	reg  [15:0]         rdata_reg;
	reg  [`AADC_DW-1:0] profile_val;
	wire [`AADC_DW-1:0] res1;
	wire [`AADC_DW-1:0] res2;
	wire                above1;
	wire                above2;
	wire                below1;
	wire                below2;
	wire [1:0]          dac_ch;
	wire                thr_ch;
	integer             i;

	assign adc1_select_out = mode_reg[`AADC_MODE_SEL1_LSB +: 3];
	assign adc2_select_out = mode_reg[`AADC_MODE_SEL2_LSB +: 3];
	assign dac_ch          = wdata_in[`AADC_DAC_CH_LSB +: 2];
	assign thr_ch          = wdata_in[`AADC_THR_CH_BIT];
	assign rdata_out       = rdata_reg;
	assign dac1_out        = dac_out_reg[0];
	assign dac2_out        = dac_out_reg[1];
	assign dac3_out        = dac_out_reg[2];
	assign dac4_out        = dac_out_reg[3];
	assign dac_enable_out  = dac_en_reg;
	assign ramp_busy_out   = ramp_active_reg;

	// ************************************************************
	// Functions
	// ************************************************************
	// Default raised cosine ramp profile, sixteen steps from zero to full scale.
	function [`AADC_DW-1:0] aadc_cosine;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: aadc_cosine = 10'h000;
				4'h1: aadc_cosine = 10'h00B;
				4'h2: aadc_cosine = 10'h02C;
				4'h3: aadc_cosine = 10'h062;
				4'h4: aadc_cosine = 10'h0A9;
				4'h5: aadc_cosine = 10'h100;
				4'h6: aadc_cosine = 10'h161;
				4'h7: aadc_cosine = 10'h1CA;
				4'h8: aadc_cosine = 10'h235;
				4'h9: aadc_cosine = 10'h29E;
				4'hA: aadc_cosine = 10'h2FF;
				4'hB: aadc_cosine = 10'h355;
				4'hC: aadc_cosine = 10'h39D;
				4'hD: aadc_cosine = 10'h3D3;
				4'hE: aadc_cosine = 10'h3F4;
				default: aadc_cosine = 10'h3FF;
			endcase
		end
	endfunction

	// A channel converts only while a real source is routed to it.
	function aadc_active;
		input [2:0] sel;
		begin
			aadc_active = (sel != `AADC_SEL_NONE);
		end
	endfunction

	// Result word: threshold status in the top bits, data in the low bits.
	function [15:0] aadc_result;
		input                hi;
		input                lo;
		input [`AADC_DW-1:0] val;
		begin
			aadc_result = {hi, lo, 4'h0, val};
		end
	endfunction

	always @* begin
		profile_val = user_profile_reg ? profile_mem[ramp_idx_reg] :
			aadc_cosine(ramp_idx_reg);
	end

	// ************************************************************
	// Sample timing
	// ************************************************************
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			tick_cnt_reg <= 14'h0000;
			tick_reg     <= 1'b0;
		end else if (ce_in) begin
			if (tick_cnt_reg == SAMPLE_CYCLES[13:0] - 14'h0001) begin
				tick_cnt_reg <= 14'h0000;
				tick_reg     <= 1'b1;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 14'h0001;
				tick_reg     <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Input channels
	// ************************************************************
	aadc_chan u_chan1 (
		.clk_in      (clk_in),
		.resetn_in   (resetn_in),
		.ce_in       (ce_in),
		.clear_in    (greset_in),
		.sample_in   (tick_reg & aadc_active(adc1_select_out)),
		.data_in     (adc1_data_in),
		.avg_en_in   (mode_reg[`AADC_MODE_AVG1_LSB +: 2] != 2'h0),
		.avg_len_in  (avg_len_reg[0]),
		.thr_high_in (thr_high_reg[0]),
		.thr_low_in  (thr_low_reg[0]),
		.result_out  (res1),
		.above_out   (above1),
		.below_out   (below1),
		.event_out   (adc_event_out[0])
	);

	aadc_chan u_chan2 (
		.clk_in      (clk_in),
		.resetn_in   (resetn_in),
		.ce_in       (ce_in),
		.clear_in    (greset_in),
		.sample_in   (tick_reg & aadc_active(adc2_select_out)),
		.data_in     (adc2_data_in),
		.avg_en_in   (mode_reg[`AADC_MODE_AVG2_LSB +: 2] != 2'h0),
		.avg_len_in  (avg_len_reg[1]),
		.thr_high_in (thr_high_reg[1]),
		.thr_low_in  (thr_low_reg[1]),
		.result_out  (res2),
		.above_out   (above2),
		.below_out   (below2),
		.event_out   (adc_event_out[1])
	);

	// ************************************************************
	// Register writes, program block and ramp
	// ************************************************************
	// The user profile array is never reset; a flag selects it, so a reset
	// falls back to the built-in profile without clearing sixteen words.
	always @(posedge clk_in) begin
		if (!resetn_in || (ce_in && greset_in)) begin
			mode_reg         <= `AADC_RESET_VALUE;
			dac_en_reg       <= 4'h0;
			user_profile_reg <= 1'b0;
			prof_ptr_reg     <= 4'h0;
			ramp_mode_reg    <= 1'b0;
			ramp_active_reg  <= 1'b0;
			ramp_up_reg      <= 1'b0;
			ramp_idx_reg     <= 4'h0;
			ramp_rate_reg    <= 4'h0;
			ramp_div_reg     <= 4'h0;
			rdata_reg        <= 16'h0000;
			for (i = 0; i < 2; i = i + 1) begin
				thr_high_reg[i] <= {`AADC_DW{1'b0}};
				thr_low_reg[i]  <= {`AADC_DW{1'b0}};
				avg_len_reg[i]  <= 4'h0;
			end
			for (i = 0; i < 4; i = i + 1) begin
				dac_lvl_reg[i] <= {`AADC_DW{1'b0}};
				dac_out_reg[i] <= {`AADC_DW{1'b0}};
			end
		end else if (ce_in) begin
			if (wr_in && addr_in == `AADC_ADDR_MODE)
				mode_reg <= wdata_in;
			if (wr_in && addr_in == `AADC_ADDR_THR) begin
				if (wdata_in[`AADC_THR_HIGH_BIT])
					thr_high_reg[thr_ch] <= wdata_in[`AADC_DW-1:0];
				else
					thr_low_reg[thr_ch] <= wdata_in[`AADC_DW-1:0];
			end
			if (wr_in && addr_in == `AADC_ADDR_DAC) begin
				dac_en_reg[dac_ch] <= wdata_in[`AADC_DAC_EN_BIT];
				if (dac_ch == 2'h0 && wdata_in[`AADC_DAC_RAMP_BIT]) begin
					ramp_mode_reg   <= 1'b1;
					ramp_active_reg <= 1'b1;
					ramp_up_reg     <= wdata_in[`AADC_DAC_EN_BIT];
					ramp_rate_reg   <= wdata_in[3:0];
					ramp_div_reg    <= 4'h0;
					ramp_idx_reg    <= wdata_in[`AADC_DAC_EN_BIT] ? 4'h0 : `AADC_RAMP_LAST;
				end else begin
					dac_lvl_reg[dac_ch] <= wdata_in[`AADC_DW-1:0];
					if (dac_ch == 2'h0) begin
						ramp_mode_reg   <= 1'b0;
						ramp_active_reg <= 1'b0;
					end
				end
			end else if (ramp_active_reg && tx_mode_in && tick_reg) begin
				if (ramp_div_reg == ramp_rate_reg) begin
					ramp_div_reg <= 4'h0;
					if (ramp_up_reg ? ramp_idx_reg == `AADC_RAMP_LAST : ramp_idx_reg == 4'h0)
						ramp_active_reg <= 1'b0;
					else
						ramp_idx_reg <= ramp_up_reg ? ramp_idx_reg + 4'h1 : ramp_idx_reg - 4'h1;
				end else begin
					ramp_div_reg <= ramp_div_reg + 4'h1;
				end
			end
			if (prog_wr_in) begin
				if (prog_addr_in == `AADC_PB_AVG_LOW)
					avg_len_reg[0] <= prog_data_in[3:0];
				if (prog_addr_in == `AADC_PB_AVG_HIGH)
					avg_len_reg[1] <= prog_data_in[3:0];
				if (prog_addr_in == `AADC_PB_RAMP_STORE) begin
					user_profile_reg <= 1'b1;
					prof_ptr_reg     <= prof_ptr_reg + 4'h1;
				end
			end
			// Outputs follow their levels in powersave too; disabled ones sit at zero, except output one in ramp mode.
			for (i = 0; i < 4; i = i + 1)
				dac_out_reg[i] <= dac_en_reg[i] ? dac_lvl_reg[i] : {`AADC_DW{1'b0}};
			if (ramp_mode_reg)
				dac_out_reg[0] <= profile_val;
			if (rd_in) begin
				case (addr_in)
					`AADC_ADDR_RES1: rdata_reg <= aadc_result(above1, below1, res1);
					`AADC_ADDR_RES2: rdata_reg <= aadc_result(above2, below2, res2);
					default:         rdata_reg <= 16'h0000;
				endcase
			end
		end
	end

	always @(posedge clk_in) begin
		if (ce_in && prog_wr_in && prog_addr_in == `AADC_PB_RAMP_STORE)
			profile_mem[prof_ptr_reg] <= prog_data_in[`AADC_DW-1:0];
	end
endmodule // aadc_top

// ===== aadc_pins.sv
// Model of the analogue sources that feed the two auxiliary input converters.
`timescale 1ns/10ps
module aadc_pins (
	input  wire       clk_in,
	input  wire [2:0] sel1_in,
	input  wire [2:0] sel2_in,
	input  wire [9:0] lvl1_in,
	input  wire [9:0] lvl2_in,
	output reg  [9:0] adc1_out,
	output reg  [9:0] adc2_out
);
	// An unrouted input has no steady source, so every code toggles each cycle.
	// A converter that kept sampling it would never see two captures agree, so its word would hold.
	initial begin
		adc1_out = 10'h155;
		adc2_out = 10'h2AA;
	end
	always @(posedge clk_in) begin
		adc1_out <= (sel1_in != 3'h0) ? lvl1_in : ~adc1_out;
		adc2_out <= (sel2_in != 3'h0) ? lvl2_in : ~adc2_out;
	end
endmodule // aadc_pins

// ===== aadc_top_checker.sv
// Concurrent checks on the ports of the auxiliary converter control block.
`timescale 1ns/10ps
`include "aadc_consts.vh"
module aadc_top_checker #(
	parameter SAMPLE_CYCLES = `AADC_SAMPLE_CYCLES
) (
	input wire                clk_in,
	input wire                resetn_in,
	input wire                ce_in,
	input wire                greset_in,
	input wire                wr_in,
	input wire                rd_in,
	input wire                tx_mode_in,
	input wire [7:0]          addr_in,
	input wire [15:0]         wdata_in,
	input wire [15:0]         rdata_out,
	input wire [2:0]          adc1_select_out,
	input wire [2:0]          adc2_select_out,
	input wire [1:0]          adc_event_out,
	input wire [`AADC_DW-1:0] dac1_out,
	input wire [`AADC_DW-1:0] dac2_out,
	input wire [`AADC_DW-1:0] dac3_out,
	input wire [3:0]          dac_enable_out,
	input wire                ramp_busy_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	sequence wr_s(logic [7:0] a);
		ce_in && !greset_in && wr_in && addr_in == a;
	endsequence
	sequence dac_wr_s(logic [3:0] hdr);
		wr_s(`AADC_ADDR_DAC) ##0 wdata_in[15:12] == hdr;
	endsequence
	// Three quiet cycles first, so a ramp load still settling is not mistaken for a step.
	sequence pause_s;
		(ramp_busy_out && !tx_mode_in && !wr_in && !greset_in && ce_in)[*3];
	endsequence
	sel_one_a: assert property (
		wr_s(`AADC_ADDR_MODE) |=> adc1_select_out == $past(wdata_in[4:2]))
		else $error("Route of input one differs from mode write.");
	sel_two_a: assert property (
		wr_s(`AADC_ADDR_MODE) |=> adc2_select_out == $past(wdata_in[9:7]))
		else $error("Route of input two differs from mode write.");
	event_once_a: assert property (
		ce_in && adc_event_out[0] |=> !adc_event_out[0])
		else $error("Threshold event lasted more than one cycle.");
	dac_set_a: assert property (
		dac_wr_s(4'hA) |=> ##1 dac2_out == $past(wdata_in[9:0], 2) && dac_enable_out[1] &&
			$stable(dac3_out))
		else $error("Output write reached the wrong channel.");
	dac_off_a: assert property (
		dac_wr_s(4'h4) |=> ##1 dac3_out == 10'h000 && !dac_enable_out[2])
		else $error("Disabled output does not drive zero.");
	ramp_go_a: assert property (
		wr_s(`AADC_ADDR_DAC) ##0 wdata_in[14:12] == 3'b001 |-> ##[1:2] ramp_busy_out)
		else $error("Ramp write did not start a ramp.");
	ramp_pause_a: assert property (
		pause_s |=> $stable(dac1_out))
		else $error("Ramp stepped outside transmit mode.");
	greset_clear_a: assert property (
		ce_in && greset_in |=> dac_enable_out == 4'h0 && adc1_select_out == 3'h0 && !ramp_busy_out)
		else $error("General reset left control state set.");
	wo_read_a: assert property (
		ce_in && rd_in && (addr_in == `AADC_ADDR_THR || addr_in == `AADC_ADDR_DAC) |=> rdata_out == 16'h0000)
		else $error("Write-only register read returned data.");
	res_hold_a: assert property (
		!(ce_in && rd_in) && !greset_in |=> $stable(rdata_out))
		else $error("Read data changed without a read.");
endmodule // aadc_top_checker

bind aadc_top aadc_top_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_aadc_top_checker (
	.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .greset_in(greset_in),
	.wr_in(wr_in), .rd_in(rd_in), .tx_mode_in(tx_mode_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .rdata_out(rdata_out), .adc1_select_out(adc1_select_out),
	.adc2_select_out(adc2_select_out), .adc_event_out(adc_event_out), .dac1_out(dac1_out),
	.dac2_out(dac2_out), .dac3_out(dac3_out), .dac_enable_out(dac_enable_out),
	.ramp_busy_out(ramp_busy_out)
);

// ===== aux_adc_dac_control_tb_top.sv
// Self-checking bench for the auxiliary converter control block.
`timescale 1ns/10ps
`include "aadc_consts.vh"
module aux_adc_dac_control_tb_top;
	localparam SC = 20;
	reg         clk_in, resetn_in, ce_in, greset_in, wr_in, rd_in, prog_wr_in, tx_mode_in;
	reg         powersave_in, pend;
	reg  [7:0]  addr_in;
	reg  [15:0] wdata_in, prog_data_in, expq[$];
	reg  [3:0]  prog_addr_in;
	reg  [9:0]  lvl1, lvl2, v, r, dv[0:3], prof[0:15];
	reg  [31:0] lf;
	wire [9:0]  a1, a2, d1, d2, d3, d4;
	wire [15:0] rdata_out;
	wire [2:0]  s1, s2;
	wire [1:0]  ev;
	wire [3:0]  den;
	wire        busy;
	integer     n_mismatch, num_checks, n_ev, n_ev2, i;

	aadc_top #(.SAMPLE_CYCLES(SC)) u_aadc_top (
		.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .greset_in(greset_in),
		.wr_in(wr_in), .rd_in(rd_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.rdata_out(rdata_out), .prog_wr_in(prog_wr_in), .prog_addr_in(prog_addr_in),
		.prog_data_in(prog_data_in), .tx_mode_in(tx_mode_in), .powersave_in(powersave_in),
		.adc1_data_in(a1), .adc2_data_in(a2), .adc1_select_out(s1), .adc2_select_out(s2),
		.adc_event_out(ev), .dac1_out(d1), .dac2_out(d2), .dac3_out(d3), .dac4_out(d4),
		.dac_enable_out(den), .ramp_busy_out(busy));
	aadc_pins u_aadc_pins (.clk_in(clk_in), .sel1_in(s1), .sel2_in(s2), .lvl1_in(lvl1),
		.lvl2_in(lvl2), .adc1_out(a1), .adc2_out(a2));

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	function [31:0] nxt(input [31:0] s);
		nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Filter fixed point: the settled value does not depend on the tick phase.
	function [9:0] fix(input [9:0] r0, input [9:0] x, input integer sh);
		reg signed [11:0] a, d;
		begin
			a = {2'b00, r0};
			d = {2'b00, x} - a;
			while ((d >>> sh) != 12'sh000) begin
				a = a + (d >>> sh);
				d = {2'b00, x} - a;
			end
			fix = a[9:0];
		end
	endfunction
	task cyc(input integer n);
		begin
			repeat (n) @(posedge clk_in);
			#2;
		end
	endtask
	task check(input [15:0] seen, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			wr_in = 1'b1;
			addr_in = a;
			wdata_in = d;
			cyc(1);
			wr_in = 1'b0;
			cyc(1);
		end
	endtask
	task rd(input [7:0] a, input [15:0] exp);
		begin
			rd_in = 1'b1;
			addr_in = a;
			expq.push_back(exp);
			cyc(1);
			rd_in = 1'b0;
			cyc(1);
		end
	endtask
	task pw(input [3:0] a, input [15:0] d);
		begin
			prog_wr_in = 1'b1;
			prog_addr_in = a;
			prog_data_in = d;
			cyc(1);
			prog_wr_in = 1'b0;
			cyc(1);
		end
	endtask
	task wait_idle;
		for (i = 0; i < 40 * SC && busy !== 1'b0; i = i + 1)
			cyc(1);
	endtask
	task complete_run;
		begin
			if (n_mismatch == 0 && num_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	always @(posedge clk_in) begin
		if (pend)
			check(rdata_out, expq.pop_front());
		pend = rd_in & ce_in;
		if (ev[0] === 1'b1)
			n_ev = n_ev + 1;
		if (ev[1] === 1'b1)
			n_ev2 = n_ev2 + 1;
	end

	initial begin
		{resetn_in, greset_in, wr_in, rd_in, prog_wr_in, tx_mode_in, powersave_in, pend} = 8'h00;
		ce_in = 1'b1;
		addr_in = 8'h00;
		wdata_in = 16'h0000;
		prog_addr_in = 4'h0;
		prog_data_in = 16'h0000;
		n_mismatch = 0;
		num_checks = 0;
		n_ev = 0;
		n_ev2 = 0;
		lf = nxt(32'hCECEB1A1);
		lvl1 = 10'h101 + {2'h0, lf[7:0]};
		lvl2 = lf[17:8] | 10'h001;
		cyc(6);
		resetn_in = 1'b1;
		// Bias is taken as already on; it lives in a register outside this block.
		wr(`AADC_ADDR_MODE, 16'h0104);
		cyc(4 * SC);
		wr(`AADC_ADDR_THR, 16'h4300);
		wr(`AADC_ADDR_THR, 16'h0100);
		cyc(2);
		n_ev = 0;
		rd(`AADC_ADDR_RES1, {6'h00, lvl1});
		rd(`AADC_ADDR_RES2, {6'h20, lvl2});
		rd(`AADC_ADDR_THR, 16'h0000);
		lvl1 = 10'h3F0;
		cyc(4 * SC);
		rd(`AADC_ADDR_RES1, 16'h83F0);
		lvl1 = 10'h050;
		cyc(4 * SC);
		rd(`AADC_ADDR_RES1, 16'h4050);
		check(n_ev[15:0], 16'h0002);
		check(n_ev2[15:0], 16'h0001);
		wr(`AADC_ADDR_MODE, 16'h0124);
		cyc(2 * SC);
		lvl1 = 10'h2C0;
		cyc(40 * SC);
		r = fix(10'h050, 10'h2C0, 1);
		rd(`AADC_ADDR_RES1, {6'h00, r});
		pw(`AADC_PB_AVG_LOW, 16'h0002);
		cyc(2 * SC);
		r = fix(r, 10'h150, 3);
		lvl1 = 10'h150;
		cyc(80 * SC);
		rd(`AADC_ADDR_RES1, {6'h00, r});
		wr(`AADC_ADDR_MODE, 16'h0120);
		lvl1 = 10'h3FF;
		cyc(4 * SC);
		rd(`AADC_ADDR_RES1, {6'h00, r});
		for (i = 0; i < 4; i = i + 1) begin
			lf = nxt(lf);
			dv[i] = lf[9:0];
			wr(`AADC_ADDR_DAC, {1'b1, i[1:0], 3'b000, lf[9:0]});
		end
		check({d1, d2[5:0]}, {dv[0], dv[1][5:0]});
		check({d3, d4[5:0]}, {dv[2], dv[3][5:0]});
		check({d2[9:6], d4[9:6], 8'h00}, {dv[1][9:6], dv[3][9:6], 8'h00});
		powersave_in = 1'b1;
		wr(`AADC_ADDR_DAC, 16'h43FF);
		cyc(5);
		check({d1, den, 2'b00}, {dv[0], 4'hB, 2'b00});
		check({6'h00, d3}, 16'h0000);
		ce_in = 1'b0;
		wr(`AADC_ADDR_DAC, 16'hA000);
		check({6'h00, d2}, {6'h00, dv[1]});
		ce_in = 1'b1;
		powersave_in = 1'b0;
		greset_in = 1'b1;
		cyc(1);
		greset_in = 1'b0;
		cyc(1);
		check({2'b00, den, s1, s2, 4'h0}, 16'h0000);
		check({6'h00, d1 | d2 | d4}, 16'h0000);
		for (i = 0; i < 16; i = i + 1) begin
			lf = nxt(lf);
			prof[i] = lf[9:0];
			pw(`AADC_PB_RAMP_STORE, {6'h00, lf[9:0]});
		end
		wr(`AADC_ADDR_DAC, 16'h9000);
		v = prof[0];
		cyc(5 * SC);
		check({5'h00, busy, d1}, {5'h00, 1'b1, v});
		tx_mode_in = 1'b1;
		wait_idle;
		check({5'h00, busy, d1}, {5'h00, 1'b0, prof[15]});
		wr(`AADC_ADDR_DAC, 16'h1001);
		wait_idle;
		check({6'h00, d1}, {6'h00, prof[0]});
		tx_mode_in = 1'b0;
		cyc(4);
		complete_run;
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch = n_mismatch + 1;
		complete_run;
	end
endmodule // aux_adc_dac_control_tb_top
